/* design/eew_defines.svh */
/*
  Constants of the serial EEPROM page-write block: opcodes, array geometry,
  status bit positions, FIFO shape and write-cycle timing.
  Assumes it is included by bare name, possibly more than once.
*/
// Function
// - One page write of up to 256 bytes inside one row (same A17..A8) is committed in one cycle.
// - A page write with fewer than 256 bytes commits only the bytes that were received.
// - After each written data byte the low eight address bits count up by one, higher bits stay put.
// - Bytes past the end of the row wrap the address to the first byte of the same row.
// - At the end of the internal write cycle the write enable latch is cleared to 0.
// - Data is stored as 38-bit words of four bytes plus six check bits, written as a unit.
// - Every read checks each 4-byte word and corrects a single wrong bit before shifting out.
// - Any write rewrites the whole 4-byte word, keeping untouched bytes, new check bits.
// - Status bit 0 is the ready/busy flag: 1 while the write cycle runs, 0 when done.
// - During the internal write cycle only the status read command is executed.
// - A write is opcode 02h, a 24-bit address and data bytes, all with chip select low.
// - Programming starts only after chip select returns high at the end of the write.
// - Without the write enable latch set, a write is ignored and standby follows CS high.
`ifndef EEW_DEFINES_SVH
`define EEW_DEFINES_SVH

// -----------------------------------------------------------------------
// opcodes
// -----------------------------------------------------------------------
`define EEW_OP_WRITE 8'h02
`define EEW_OP_READ 8'h03
`define EEW_OP_WRDIS 8'h04
`define EEW_OP_STAT 8'h05
`define EEW_OP_WREN 8'h06

// -----------------------------------------------------------------------
// geometry and status layout
// -----------------------------------------------------------------------
`define EEW_ADDR_W 18
`define EEW_ROW_BYTES 256
`define EEW_ROW_WORDS 64
`define EEW_ARRAY_WORDS 65536
`define EEW_DATA_W 32
`define EEW_CODE_W 38
`define EEW_CHECK_W 6
`define EEW_STAT_BUSY_BIT 0
`define EEW_STAT_WEL_BIT 1

// -----------------------------------------------------------------------
// buffering and timing
// -----------------------------------------------------------------------
`define EEW_FIFO_DEPTH 32
`define EEW_FIFO_W 16
`define EEW_CLK_MHZ 125
`define EEW_T_WC_US 10000
`define EEW_WC_CYCLES (`EEW_T_WC_US * `EEW_CLK_MHZ)

`endif

/* design/eew_pkg.sv */
/*
  Types of the page-write block: serial phases, commit states, state record.
  Assumes eew_defines.svh is on the include path.
*/
`include "eew_defines.svh"

package eew_pkg;

  // -----------------------------------------------------------------------
  // enumerations
  // -----------------------------------------------------------------------
  typedef enum {PH_CMD, PH_ADDR, PH_DATA, PH_STAT, PH_IGNORE} eew_phase_t;
  typedef enum {CS_IDLE, CS_DRAIN, CS_PROG, CS_WAIT} eew_cstate_t;

  // -----------------------------------------------------------------------
  // complete state of the top module
  // -----------------------------------------------------------------------
  typedef struct packed {
    logic sck_q;
    logic cs_n_q;
    eew_phase_t phase;
    logic [7:0] cmd;
    logic [7:0] sh_in;
    logic [2:0] bit_cnt;
    logic [1:0] addr_cnt;
    logic [`EEW_ADDR_W-1:0] addr;
    logic [7:0] sh_out;
    logic so;
    logic so_oe;
    logic write_enable_latch;
    logic busy;
    logic wr_armed;
    logic got_data;
    logic push;
    logic [`EEW_FIFO_W-1:0] push_data;
    eew_cstate_t cstate;
    logic [5:0] word_idx;
    logic [20:0] timer;
    logic [`EEW_ROW_BYTES-1:0] page_valid;
  } eew_state_t;

endpackage

/* design/eew_stream_if.sv */
/*
  Valid/ready stream carrier between the page-write core and its FIFO.
  Assumes both ends share one clock.
*/
`timescale 1ns/10ps

interface eew_stream_if #(parameter int W = 16);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* design/eew_fifo.sv */
/*
  Synchronous FIFO, width and depth as parameters, valid/ready on both sides.
  Assumes DEPTH is a power of two and one clock with a clock enable.
*/
`timescale 1ns/10ps
`include "eew_defines.svh"

module eew_fifo #(
  parameter int WIDTH = `EEW_FIFO_W,
  parameter int DEPTH = `EEW_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  eew_stream_if.snk wr,
  eew_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;
  } eew_fifo_state_t;

  eew_fifo_state_t fs_reg, fs_next;
  logic [WIDTH-1:0] buf_mem [DEPTH];
  logic push, pop;

  assign wr.ready = fs_reg.count != (AW+1)'(DEPTH);
  assign rd.valid = fs_reg.count != '0;
  assign rd.data = buf_mem[fs_reg.rp];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  always_comb begin
    fs_next = fs_reg;
    if (push) begin
      fs_next.wp = fs_reg.wp + 1'b1;
    end
    if (pop) begin
      fs_next.rp = fs_reg.rp + 1'b1;
    end
    fs_next.count = fs_reg.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fs_reg <= '0;
    end else if (en) begin
      fs_reg <= fs_next;
    end
  end

  always_ff @(posedge clk) begin
    if (en && push) begin
      buf_mem[fs_reg.wp] <= wr.data;
    end
  end

  AST_FIFO_COUNT: assert property (@(posedge clk) disable iff (rst)
    en && push && !pop |=> fs_reg.count == $past(fs_reg.count) + 1'b1)
    else $error("fifo count did not follow a push");

endmodule // eew_fifo

/* design/eew_page_write.sv */
/*
  Serial EEPROM page-write path: mode-0 serial slave, row page buffer fed
  through a FIFO, 38-bit Hamming-protected array, self-timed write cycle.
  Assumes CS_N, SCK and SI are synchronous to CLK_SYS and SCK is far slower.
*/
`timescale 1ns/10ps
`include "eew_defines.svh"

module eew_page_write
  import eew_pkg::*;
#(
  parameter int WC_CYCLES = `EEW_WC_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic CE,
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SI,
  output logic SO,
  output logic SO_OE,
  output logic BUSY
);

  // -----------------------------------------------------------------------
  // storage
  // -----------------------------------------------------------------------
  eew_state_t st_reg, st_next;
  logic [`EEW_CODE_W-1:0] mem [`EEW_ARRAY_WORDS];
  logic [7:0] page_mem [`EEW_ROW_BYTES];

  eew_stream_if #(.W(`EEW_FIFO_W)) push_if ();
  eew_stream_if #(.W(`EEW_FIFO_W)) pop_if ();

  eew_fifo #(.WIDTH(`EEW_FIFO_W), .DEPTH(`EEW_FIFO_DEPTH)) u_fifo (
    .clk(CLK_SYS),
    .rst(RESET),
    .en(CE),
    .wr(push_if),
    .rd(pop_if)
  );

  // -----------------------------------------------------------------------
  // hamming code, check bits at power-of-two positions
  // -----------------------------------------------------------------------
  function automatic logic [`EEW_CODE_W-1:0] ecc_encode(input logic [`EEW_DATA_W-1:0] d);
    logic [`EEW_CODE_W-1:0] c;
    int j;
    c = '0;
    j = 0;
    for (int p = 1; p <= `EEW_CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p-1] = d[j];
        j++;
      end
    end
    for (int k = 0; k < `EEW_CHECK_W; k++) begin
      for (int p = 1; p <= `EEW_CODE_W; p++) begin
        if (p[k] && (p & (p - 1)) != 0) begin
          c[(1 << k) - 1] = c[(1 << k) - 1] ^ c[p-1];
        end
      end
    end
    return c;
  endfunction

  function automatic logic [`EEW_DATA_W-1:0] ecc_decode(input logic [`EEW_CODE_W-1:0] c_in);
    logic [`EEW_CODE_W-1:0] c;
    logic [`EEW_CHECK_W-1:0] s;
    logic [`EEW_DATA_W-1:0] d;
    int j;
    c = c_in;
    s = '0;
    d = '0;
    j = 0;
    for (int k = 0; k < `EEW_CHECK_W; k++) begin
      for (int p = 1; p <= `EEW_CODE_W; p++) begin
        if (p[k]) begin
          s[k] = s[k] ^ c[p-1];
        end
      end
    end
    // a syndrome beyond the code length is a multi-bit error; left alone
    if (s != '0 && int'(s) <= `EEW_CODE_W) begin
      c[int'(s) - 1] = ~c[int'(s) - 1];
    end
    for (int p = 1; p <= `EEW_CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[j] = c[p-1];
        j++;
      end
    end
    return d;
  endfunction

  // -----------------------------------------------------------------------
  // array access: read-modify-write of one word per cycle while committing
  // -----------------------------------------------------------------------
  logic [15:0] prog_word, rd_idx;
  logic [3:0] prog_mask;
  logic [`EEW_DATA_W-1:0] rd_data, merged;
  logic [`EEW_CODE_W-1:0] wr_code;
  logic mem_we;

  assign prog_word = {st_reg.addr[`EEW_ADDR_W-1:8], st_reg.word_idx};
  assign prog_mask = st_reg.page_valid[{st_reg.word_idx, 2'h0} +: 4];
  assign rd_idx = (st_reg.cstate == CS_PROG) ? prog_word : st_reg.addr[`EEW_ADDR_W-1:2];
  assign rd_data = ecc_decode(mem[rd_idx]);
  assign wr_code = ecc_encode(merged);
  assign mem_we = CE && st_reg.cstate == CS_PROG && prog_mask != 4'h0;

  always_comb begin
    merged = rd_data;
    for (int b = 0; b < 4; b++) begin
      if (prog_mask[b]) begin
        merged[8*b +: 8] = page_mem[{st_reg.word_idx, 2'(b)}];
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (mem_we) begin
      mem[prog_word] <= wr_code;
    end
    if (CE && pop_if.valid && pop_if.ready) begin
      page_mem[pop_if.data[15:8]] <= pop_if.data[7:0];
    end
  end

  // -----------------------------------------------------------------------
  // fifo hookup
  // -----------------------------------------------------------------------
  assign push_if.valid = st_reg.push;
  assign push_if.data = st_reg.push_data;
  // page buffer is frozen while the array is being programmed
  assign pop_if.ready = st_reg.cstate == CS_IDLE || st_reg.cstate == CS_DRAIN;

  // -----------------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------------
  logic sck_rise, sck_fall, byte_done, write_push;
  logic [7:0] rx_byte, tx_byte, stat_byte;

  assign sck_rise = !CS_N && SCK && !st_reg.sck_q;
  assign sck_fall = !CS_N && !SCK && st_reg.sck_q;
  assign rx_byte = {st_reg.sh_in[6:0], SI};
  assign byte_done = sck_rise && st_reg.bit_cnt == 3'h7;
  assign write_push = byte_done && st_reg.phase == PH_DATA && st_reg.cmd == `EEW_OP_WRITE
    && st_reg.wr_armed && push_if.ready;

  always_comb begin
    stat_byte = 8'h00;
    stat_byte[`EEW_STAT_BUSY_BIT] = st_reg.busy;
    stat_byte[`EEW_STAT_WEL_BIT] = st_reg.write_enable_latch;
    tx_byte = (st_reg.phase == PH_STAT) ? stat_byte : rd_data[{st_reg.addr[1:0], 3'h0} +: 8];

    st_next = st_reg;
    st_next.push = 1'b0;
    st_next.sck_q = SCK;
    st_next.cs_n_q = CS_N;

    if (CS_N) begin
      st_next.phase = PH_CMD;
      st_next.bit_cnt = 3'h0;
      st_next.addr_cnt = 2'h0;
      st_next.so_oe = 1'b0;
      if (!st_reg.cs_n_q) begin
        if (st_reg.wr_armed && st_reg.got_data && st_reg.cstate == CS_IDLE) begin
          st_next.cstate = CS_DRAIN;
          st_next.busy = 1'b1;
        end else if (st_reg.cstate == CS_IDLE) begin
          st_next.wr_armed = 1'b0;
        end
      end
    end else begin
      if (sck_rise) begin
        st_next.sh_in = rx_byte;
        st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
      end
      if (byte_done) begin
        unique case (st_reg.phase)
          PH_CMD: begin
            st_next.cmd = rx_byte;
            st_next.phase = PH_IGNORE;
            if (!st_reg.busy || rx_byte == `EEW_OP_STAT) begin
              case (rx_byte)
                `EEW_OP_STAT: st_next.phase = PH_STAT;
                `EEW_OP_WREN: st_next.write_enable_latch = 1'b1;
                `EEW_OP_WRDIS: st_next.write_enable_latch = 1'b0;
                `EEW_OP_READ: st_next.phase = PH_ADDR;
                `EEW_OP_WRITE: begin
                  st_next.phase = PH_ADDR;
                  st_next.wr_armed = st_reg.write_enable_latch;
                end
                default: st_next.phase = PH_IGNORE;
              endcase
            end
          end
          PH_ADDR: begin
            st_next.addr = {st_reg.addr[`EEW_ADDR_W-9:0], rx_byte};
            st_next.addr_cnt = st_reg.addr_cnt + 2'h1;
            if (st_reg.addr_cnt == 2'h2) begin
              st_next.phase = PH_DATA;
            end
          end
          PH_DATA: begin
            if (write_push) begin
              st_next.push = 1'b1;
              st_next.push_data = {st_reg.addr[7:0], rx_byte};
              // only the low byte moves, so an overrun wraps inside the row
              st_next.addr[7:0] = st_reg.addr[7:0] + 8'h01;
              st_next.got_data = 1'b1;
            end
          end
          PH_STAT, PH_IGNORE: begin
          end
        endcase
      end
      if (sck_fall && (st_reg.phase == PH_STAT
          || (st_reg.phase == PH_DATA && st_reg.cmd == `EEW_OP_READ))) begin
        if (st_reg.bit_cnt == 3'h0) begin
          st_next.so = tx_byte[7];
          st_next.sh_out = {tx_byte[6:0], 1'b0};
          st_next.so_oe = 1'b1;
          if (st_reg.phase == PH_DATA) begin
            st_next.addr = st_reg.addr + 18'h00001;
          end
        end else begin
          st_next.so = st_reg.sh_out[7];
          st_next.sh_out = {st_reg.sh_out[6:0], 1'b0};
        end
      end
    end

    if (pop_if.valid && pop_if.ready) begin
      st_next.page_valid[pop_if.data[15:8]] = 1'b1;
    end

    unique case (st_reg.cstate)
      CS_IDLE: begin
      end
      CS_DRAIN: begin
        if (!pop_if.valid) begin
          st_next.cstate = CS_PROG;
          st_next.word_idx = 6'h00;
        end
      end
      CS_PROG: begin
        st_next.word_idx = st_reg.word_idx + 6'h01;
        if (st_reg.word_idx == 6'(`EEW_ROW_WORDS - 1)) begin
          st_next.cstate = CS_WAIT;
          st_next.timer = 21'(WC_CYCLES - 1);
        end
      end
      CS_WAIT: begin
        if (st_reg.timer == 21'h000000) begin
          st_next.cstate = CS_IDLE;
          st_next.busy = 1'b0;
          st_next.write_enable_latch = 1'b0;
          st_next.wr_armed = 1'b0;
          st_next.got_data = 1'b0;
          st_next.page_valid = '0;
        end else begin
          st_next.timer = st_reg.timer - 21'h000001;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      st_reg <= '0;
      // deselected level, so no false chip-select rise follows reset
      st_reg.cs_n_q <= 1'b1;
    end else if (CE) begin
      st_reg <= st_next;
    end
  end

  assign SO = st_reg.so;
  assign SO_OE = st_reg.so_oe;
  assign BUSY = st_reg.busy;

  // -----------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------
  AST_WEL_CLEAR: assert property (@(posedge CLK_SYS) disable iff (RESET)
    CE && st_reg.cstate == CS_WAIT && st_reg.timer == 21'h000000
    |=> !st_reg.write_enable_latch && !st_reg.busy && st_reg.cstate == CS_IDLE)
    else $error("write enable latch not cleared at end of write cycle");

  AST_ADDR_INC: assert property (@(posedge CLK_SYS) disable iff (RESET)
    CE && write_push |=> st_reg.addr[`EEW_ADDR_W-1:8] == $past(st_reg.addr[`EEW_ADDR_W-1:8])
    && st_reg.addr[7:0] == $past(st_reg.addr[7:0]) + 8'h01)
    else $error("address did not step by one within the row");

  AST_ROW_WRAP: assert property (@(posedge CLK_SYS) disable iff (RESET)
    CE && write_push && st_reg.addr[7:0] == 8'hff |=> st_reg.addr[7:0] == 8'h00)
    else $error("address did not wrap to the row start");

  AST_BUSY_HELD: assert property (@(posedge CLK_SYS) disable iff (RESET)
    st_reg.cstate != CS_IDLE |-> st_reg.busy)
    else $error("busy flag low while write cycle runs");

  AST_IGNORE_BUSY: assert property (@(posedge CLK_SYS) disable iff (RESET)
    CE && byte_done && st_reg.phase == PH_CMD && st_reg.busy && rx_byte != `EEW_OP_STAT
    |=> st_reg.phase == PH_IGNORE && st_reg.write_enable_latch == $past(st_reg.write_enable_latch))
    else $error("instruction executed during write cycle");

  AST_NO_WEL: assert property (@(posedge CLK_SYS) disable iff (RESET)
    CE && byte_done && st_reg.phase == PH_CMD && !st_reg.busy && !st_reg.write_enable_latch
    && rx_byte == `EEW_OP_WRITE |=> !st_reg.wr_armed)
    else $error("write armed without write enable latch");

  AST_START_CS_HIGH: assert property (@(posedge CLK_SYS) disable iff (RESET)
    CE && st_reg.cstate == CS_IDLE ##1 st_reg.cstate == CS_DRAIN |-> $past(CS_N))
    else $error("programming started with chip select low");

  AST_PROG_END: assert property (@(posedge CLK_SYS) disable iff (RESET)
    CE && st_reg.cstate == CS_PROG && st_reg.word_idx == 6'h3f |=> st_reg.cstate == CS_WAIT
    && st_reg.timer == 21'(WC_CYCLES - 1))
    else $error("row commit did not end after its last word");

  AST_ECC_FIX: assert property (@(posedge CLK_SYS) disable iff (RESET)
    mem_we |-> ecc_decode(wr_code ^ (38'h1 << st_reg.word_idx)) == merged)
    else $error("single bit error not corrected");

endmodule // eew_page_write

/* bench/eew_host_model.sv */
/*
  Serial host model for the page-write block: mode 0, SCK idle low, MSB first.
  Assumes the bench calls its tasks at falling edges of clk; SCK half period in half.
*/
`timescale 1ns/10ps

module eew_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so
);
  int half = 4;

  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  // -----------------------------------------------------------------------
  // framing and byte transfer
  // -----------------------------------------------------------------------
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic frame_begin();
    cs_n = 1'b0;
    idle(3);
  endtask

  // released line shows the inverse of its last bit, never a stale copy
  task automatic frame_end();
    idle(3);
    cs_n = 1'b1;
    si = ~si;
    idle(3);
  endtask

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      idle(half);
      rx[i] = so;
      sck = 1'b1;
      idle(half);
      sck = 1'b0;
    end
  endtask
endmodule // eew_host_model

/* bench/eew_page_write_tb.sv */
/*
  Self-checking bench of the page-write block, one task per scenario.
  Assumes the host model and a shortened write cycle via WC_CYCLES.
*/
`timescale 1ns/10ps
`include "eew_defines.svh"

`define CHK(what, exp, got) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("mismatch %s expected %0h seen %0h", what, exp, got); \
  end \
end

module eew_page_write_tb;
  // long enough that a status poll and an ignored read both fit in it
  localparam int WC = 1000;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic cs_n, sck, si, so, so_oe, busy;
  int n_mismatch = 0;
  int n_checks = 0;
  logic [7:0] rx;
  logic [7:0] st;
  logic [7:0] pg[$];

  always #4 clk_sys = ~clk_sys;

  eew_page_write #(.WC_CYCLES(WC)) uut (.CLK_SYS(clk_sys), .RESET(reset), .CE(ce),
    .CS_N(cs_n), .SCK(sck), .SI(si), .SO(so), .SO_OE(so_oe), .BUSY(busy));
  // an undriven output line shows the inverse of its last value
  eew_host_model host (.clk(clk_sys), .cs_n(cs_n), .sck(sck), .si(si),
    .so(so_oe ? so : ~so));

  // -----------------------------------------------------------------------
  // shared bus tasks
  // -----------------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] op);
    host.frame_begin();
    host.xfer(op, rx);
    host.frame_end();
  endtask

  task automatic status(output logic [7:0] s);
    host.frame_begin();
    host.xfer(`EEW_OP_STAT, rx);
    host.xfer(8'h00, s);
    host.frame_end();
  endtask

  task automatic send_addr(input logic [7:0] op, input logic [23:0] a);
    host.xfer(op, rx);
    host.xfer(a[23:16], rx);
    host.xfer(a[15:8], rx);
    host.xfer(a[7:0], rx);
  endtask

  task automatic write_bytes(input logic [23:0] a, input logic [7:0] d[$], input logic go);
    host.frame_begin();
    send_addr(`EEW_OP_WRITE, a);
    foreach (d[i]) host.xfer(d[i], rx);
    `CHK("busy while selected", 1'b0, busy)
    host.frame_end();
    `CHK("busy after deselect", go, busy)
  endtask

  task automatic wait_ready();
    int k;
    st = 8'h01;
    for (k = 0; k < 40 && st[0] !== 1'b0; k++) status(st);
    if (k == 40) begin
      n_mismatch++;
      stop_test();
    end
    `CHK("status after cycle", 8'h00, st)
    `CHK("busy pin after cycle", 1'b0, busy)
  endtask

  task automatic check_read(input logic [23:0] a, input logic [7:0] e[$]);
    logic [7:0] b;
    host.frame_begin();
    send_addr(`EEW_OP_READ, a);
    foreach (e[i]) begin
      host.xfer(8'h00, b);
      `CHK("read byte", e[i], b)
    end
    host.frame_end();
  endtask

  // -----------------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------------
  task automatic t_reset();
    `CHK("so_oe idle", 1'b0, so_oe)
    `CHK("busy idle", 1'b0, busy)
    status(st);
    `CHK("status idle", 8'h00, st)
  endtask

  task automatic t_no_wel();
    write_bytes(24'h000010, {8'h11}, 1'b0);
    status(st);
    `CHK("status after refused write", 8'h00, st)
  endtask

  // full aligned row; upper address bits above A17 are don't care
  task automatic t_page();
    for (int i = 0; i < 256; i++) pg.push_back(8'(i) ^ 8'h5a);
    cmd(`EEW_OP_WREN);
    status(st);
    `CHK("latch set", 8'h02, st)
    write_bytes(24'hfc0200, pg, 1'b1);
    status(st);
    `CHK("busy flag", 1'b1, st[0])
    host.frame_begin();
    send_addr(`EEW_OP_READ, 24'h000200);
    host.xfer(8'h00, rx);
    `CHK("read ignored while busy", 1'b0, so_oe)
    host.frame_end();
    wait_ready();
    check_read(24'h000200, pg);
  endtask

  // single byte in mid-word, slow serial clock
  task automatic t_partial();
    host.half = 7;
    cmd(`EEW_OP_WREN);
    write_bytes(24'h000205, {8'ha5}, 1'b1);
    // frozen clock enable must stretch the write cycle past its length
    ce = 1'b0;
    host.idle(1200);
    `CHK("busy held while frozen", 1'b1, busy)
    ce = 1'b1;
    wait_ready();
    host.half = 4;
    check_read(24'h000204, {pg[4], 8'ha5, pg[6], pg[7]});
  endtask

  // deliberate row overrun, breaking the host's advice to probe the wrap
  task automatic t_wrap();
    cmd(`EEW_OP_WREN);
    write_bytes(24'h0002fe, {8'hc1, 8'hc2, 8'hc3}, 1'b1);
    wait_ready();
    check_read(24'h0002fe, {8'hc1, 8'hc2});
    check_read(24'h000200, {8'hc3, pg[1]});
  endtask

  initial begin
    repeat (3) @(negedge clk_sys);
    reset = 1'b0;
    repeat (3) @(negedge clk_sys);
    t_reset();
    t_no_wel();
    t_page();
    t_partial();
    t_wrap();
    stop_test();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    n_mismatch++;
    stop_test();
  end
endmodule // eew_page_write_tb
